// ==== shared/ccp_params.svh ====
// Constants for the codec control-port front end.
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH
`define CCP_ADDR_MSBS      5'h06
`define CCP_BYTE_BITS      4'h8
`define CCP_WORD_BITS      5'h10
`define CCP_SYNC_STAGES    3
`define CCP_RST_MIN_NS     10
`define CCP_CLK_PERIOD_NS  10
`define CCP_I2C_STD_HZ     100000
`define CCP_I2C_FAST_HZ    400000
`define CCP_CMD_LAST       4'h7
`define CCP_DATA_LAST      4'hF
`define CCP_FILL_DONE      2'h3
`define CCP_PIN_COUNT      5
`define CCP_PIN_SEL        0
`define CCP_PIN_SS         1
`define CCP_PIN_CLK        2
`define CCP_PIN_MOSI       3
`define CCP_PIN_AB1        4
`define CCP_PIN_IDLE       5'h02
`define CCP_NS_PER_S       1000000000
`define CCP_MIN_SAMPLES    8
`endif

// ==== shared/ccp_pkg.sv ====
// Types for the codec control-port front end.
package ccp_pkg;
  typedef enum logic [1:0] {
    CCP_IDLE,
    CCP_CMD,
    CCP_DATA,
    CCP_DONE
  } ccp_spi_state_t;
endpackage

// ==== rtl/ccp_front_end.sv ====
// Control-port front end: protocol strap, SPI command framing and I2C address.
// Function
// - Accesses valid only after reset pulse.
// - Select high gives SPI, low gives I2C.
// - I2C accepts standard and fast rates.
// - Two address pins pick one of four.
// - I2C address is 00110 then pin1, pin0.
// - Command: address upper seven, bit0 read flag.
// - First byte command, second data on write.
`timescale 1ns/100ps
`default_nettype none
`include "ccp_params.svh"
module ccp_front_end (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Straps and multifunction pins.
  input  wire logic       protocol_select,
  input  wire logic       slave_select_or_addr_lsb_pin,
  input  wire logic       addr_bit1_pin,
  // SPI link.
  input  wire logic       spi_sclk,
  input  wire logic       spi_mosi,
  output logic            spi_miso_o,
  output logic            spi_miso_oe,
  // Register access towards the register file.
  input  wire logic [7:0] reg_rdata,
  output logic [6:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  // Mode and address status.
  output logic            spi_mode,
  output logic [6:0]      i2c_slave_addr
);
  // Every pin from outside the clock domain passes three stages. Its filtered
  // level follows only when stages two and three agree, so a single sample
  // caught mid-transition never counts as an edge.
  localparam logic [`CCP_PIN_COUNT-1:0] PIN_IDLE = `CCP_PIN_IDLE;

  wire  [`CCP_PIN_COUNT-1:0]   pin_raw;
  wire  [`CCP_PIN_COUNT-1:0]   agree;
  wire  [`CCP_PIN_COUNT-1:0]   level_next;
  logic [`CCP_SYNC_STAGES-1:0] sync_q [`CCP_PIN_COUNT];
  logic [`CCP_PIN_COUNT-1:0]   level_q;
  logic [1:0]                  fill_q;
  logic                        captured_q;
  logic [3:0]                  bit_cnt_q;
  logic [7:0]                  shift_q;
  logic [7:0]                  tx_q;
  logic                        is_read_q;
  ccp_pkg::ccp_spi_state_t     state_q;

  // True when the two oldest stages of a synchroniser hold the same level.
  function automatic logic stages_agree(input logic [`CCP_SYNC_STAGES-1:0] s);
    stages_agree = s[`CCP_SYNC_STAGES-1] == s[`CCP_SYNC_STAGES-2];
  endfunction

  assign pin_raw[`CCP_PIN_SEL]  = protocol_select;
  assign pin_raw[`CCP_PIN_SS]   = slave_select_or_addr_lsb_pin;
  assign pin_raw[`CCP_PIN_CLK]  = spi_sclk;
  assign pin_raw[`CCP_PIN_MOSI] = spi_mosi;
  assign pin_raw[`CCP_PIN_AB1]  = addr_bit1_pin;

  // Reset fills each chain with the idle level of its pin, so that no false
  // edge appears when the first real samples arrive.
  for (genvar g = 0; g < `CCP_PIN_COUNT; g++) begin : g_pin
    assign agree[g]      = stages_agree(sync_q[g]);
    assign level_next[g] = agree[g] ? sync_q[g][`CCP_SYNC_STAGES-1] : level_q[g];

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        sync_q[g]  <= {`CCP_SYNC_STAGES{PIN_IDLE[g]}};
        level_q[g] <= PIN_IDLE[g];
      end else begin
        sync_q[g] <= {sync_q[g][`CCP_SYNC_STAGES-2:0], pin_raw[g]};
        if (agree[g]) begin
          level_q[g] <= sync_q[g][`CCP_SYNC_STAGES-1];
        end
      end
    end
  end

  wire ss_lvl    = level_q[`CCP_PIN_SS];
  wire ss_next   = level_next[`CCP_PIN_SS];
  wire clk_lvl   = level_q[`CCP_PIN_CLK];
  wire clk_next  = level_next[`CCP_PIN_CLK];
  wire mosi_lvl  = level_q[`CCP_PIN_MOSI];
  wire ab1_lvl   = level_q[`CCP_PIN_AB1];
  wire ss_fall   = ss_lvl && !ss_next;
  wire clk_rise  = !clk_lvl && clk_next;
  wire clk_fall  = clk_lvl && !clk_next;
  wire fill_done = fill_q == `CCP_FILL_DONE;
  wire sel_ok    = fill_done && agree[`CCP_PIN_SEL];
  wire sel_pin   = sync_q[`CCP_PIN_SEL][`CCP_SYNC_STAGES-1];

  // The strap is taken once, and only after the chain holds samples taken
  // since reset release; its reset fill alone would always pick I2C.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fill_q         <= 2'h0;
      captured_q     <= 1'h0;
      spi_mode       <= 1'h0;
      i2c_slave_addr <= 7'h00;
    end else begin
      if (!fill_done) begin
        fill_q <= fill_q + 2'h1;
      end
      if (!captured_q && sel_ok) begin
        captured_q <= 1'h1;
        spi_mode   <= sel_pin;
      end
      // The address LSB pin shares the SPI select pin; meaningful only in I2C mode.
      i2c_slave_addr <= {`CCP_ADDR_MSBS, ab1_lvl, ss_lvl};
    end
  end

  // Nothing is decoded before a strap has been taken after a reset pulse.
  wire       spi_active = captured_q && spi_mode;
  wire       cmd_last   = (state_q == ccp_pkg::CCP_CMD) && (bit_cnt_q == `CCP_CMD_LAST);
  wire       data_last  = (state_q == ccp_pkg::CCP_DATA) && (bit_cnt_q == `CCP_DATA_LAST);
  wire       tx_first   = bit_cnt_q == `CCP_BYTE_BITS;
  wire       tx_shift   = clk_rise && (state_q == ccp_pkg::CCP_DATA) && is_read_q;
  wire [7:0] shift_next = {shift_q[6:0], mosi_lvl};

  // A rising select ends the frame at once, even mid-byte; a host that lifts
  // select in the same sample as its last falling clock, or earlier, loses that bit.

  // SPI framing: CPOL 0, CPHA 1; drive on rising edge, sample on falling edge.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ccp_pkg::CCP_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      is_read_q <= 1'h0;
      reg_addr  <= 7'h00;
      reg_wdata <= 8'h00;
      reg_wr    <= 1'h0;
      reg_rd    <= 1'h0;
      spi_miso_o  <= 1'h0;
      spi_miso_oe <= 1'h0;
    end else begin
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      if (!spi_active || ss_next) begin
        state_q     <= ccp_pkg::CCP_IDLE;
        spi_miso_oe <= 1'h0;
      end else begin
        spi_miso_oe <= is_read_q && (state_q == ccp_pkg::CCP_DATA);
        unique case (state_q)
          ccp_pkg::CCP_IDLE: begin
            if (ss_fall) begin
              state_q   <= ccp_pkg::CCP_CMD;
              bit_cnt_q <= 4'h0;
              is_read_q <= 1'h0;
            end
          end
          ccp_pkg::CCP_CMD, ccp_pkg::CCP_DATA: begin
            if (clk_fall) begin
              shift_q <= shift_next;
              if (cmd_last) begin
                reg_addr  <= shift_next[7:1];
                is_read_q <= shift_next[0];
                reg_rd    <= shift_next[0];
                state_q   <= ccp_pkg::CCP_DATA;
              end else if (data_last) begin
                reg_wdata <= shift_next;
                reg_wr    <= !is_read_q;
                state_q   <= ccp_pkg::CCP_DONE;
              end
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            // Read data leaves on rising edges so the host samples it on falling ones.
            if (tx_shift) begin
              if (tx_first) begin
                spi_miso_o <= reg_rdata[7];
                tx_q       <= {reg_rdata[6:0], 1'h0};
              end else begin
                spi_miso_o <= tx_q[7];
                tx_q       <= {tx_q[6:0], 1'h0};
              end
            end
          end
          ccp_pkg::CCP_DONE: begin
            spi_miso_oe <= 1'h0;
          end
        endcase
      end
    end
  end

  // The fill counter must cover exactly the synchroniser depth.
  if (int'(`CCP_FILL_DONE) != `CCP_SYNC_STAGES) begin : g_bad_sync
    $error("Synchroniser depth does not match the fill count.");
  end

  // The pin filter needs several samples per bus clock period at either rate.
  if ((`CCP_NS_PER_S / `CCP_I2C_FAST_HZ < `CCP_MIN_SAMPLES * `CCP_CLK_PERIOD_NS) ||
      (`CCP_NS_PER_S / `CCP_I2C_STD_HZ < `CCP_MIN_SAMPLES * `CCP_CLK_PERIOD_NS))
  begin : g_bad_rate
    $error("Clock too slow to sample the address pins at bus rate.");
  end
endmodule // ccp_front_end
`default_nettype wire

// ==== bench/ccp_front_end_sva.sv ====
// Checker on the control-port front end ports.
`timescale 1ns/100ps
`default_nettype none
module ccp_front_end_sva (
  // Watched ports.
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       spi_mode,
  input wire logic       spi_miso_oe,
  input wire logic [6:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [6:0] i2c_slave_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_strobe_excl: assert property (!(reg_wr && reg_rd)) else $error("two strobes");
  a_wr_pulse: assert property (reg_wr |=> !reg_wr) else $error("long write");
  a_rd_pulse: assert property (reg_rd |=> !reg_rd) else $error("long read");
  a_i2c_quiet: assert property (!spi_mode |-> !reg_wr && !reg_rd && !spi_miso_oe)
    else $error("spi activity in i2c mode");
  a_mode_hold: assert property (spi_mode |=> spi_mode) else $error("mode lost");
  a_addr_msbs: assert property ($past(rst_n) |-> i2c_slave_addr[6:2] == 5'h06)
    else $error("bad address msbs");
  a_wr_addr_hold: assert property (reg_wr |-> $stable(reg_addr)) else $error("addr moved");
  a_rd_no_wr: assert property (reg_rd |=> !reg_wr [*8]) else $error("write on read");
endmodule // ccp_front_end_sva
bind ccp_front_end ccp_front_end_sva ccp_front_end_sva_i (.clock, .rst_n, .spi_mode,
  .spi_miso_oe, .reg_addr, .reg_wr, .reg_rd, .i2c_slave_addr);
`default_nettype wire

// ==== bench/ccp_host.sv ====
// SPI host model with a 125 ns bit period.
`timescale 1ns/100ps
`default_nettype none
module ccp_host (
  // SPI lines.
  output logic      sel_n,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    sel_n = 1'b0;
    #62.5;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
      rx[i] = miso;
      #62.5;
    end
    #62.5;
    sel_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule // ccp_host
`default_nettype wire

// ==== bench/codec_control_port_front_end_tb.sv ====
// Self-checking bench for the control-port front end.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t ns: value mismatch", $time); end end
module codec_control_port_front_end_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        b1 = 1'b0;
  logic [7:0]  rdata = 8'h00;
  logic [15:0] rx;
  wire         sel, sclk, mosi, miso, miso_o, oe, wr, rd, mode;
  wire  [6:0]  addr, i2c_addr;
  wire  [7:0]  wdata;
  int          n_errors = 0, total_checks = 0, n_wr = 0, n_rd = 0;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    n_wr <= n_wr + int'(wr);
    n_rd <= n_rd + int'(rd);
  end
  assign miso = oe ? miso_o : 1'bz;
  ccp_front_end ccp_front_end_i (.clock, .rst_n, .protocol_select(psel),
    .slave_select_or_addr_lsb_pin(sel), .addr_bit1_pin(b1), .spi_sclk(sclk),
    .spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe(oe), .reg_rdata(rdata),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .spi_mode(mode),
    .i2c_slave_addr(i2c_addr));
  ccp_host ccp_host_i (.sel_n(sel), .sclk, .mosi, .miso);
  task end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task do_rst(input logic p);
    @(negedge clock);
    psel = p;
    rst_n = 1'b0;
    repeat (6) @(negedge clock);
    `CHK(mode, 1'b0)
    rst_n = 1'b1;
    repeat (8) @(negedge clock);
    `CHK(mode, p)
  endtask
  task t_i2c;
    do_rst(1'b0);
    for (int i = 0; i < 4; i++) begin
      b1 = i[1];
      ccp_host_i.sel_n = i[0];
      repeat (10) @(negedge clock);
      `CHK(i2c_addr, {5'h06, i[1:0]})
    end
    ccp_host_i.xfer(16'hAAA3, rx);
    `CHK(n_wr + n_rd, 0)
  endtask
  task t_spi_wr;
    do_rst(1'b1);
    ccp_host_i.xfer({7'h55, 1'b0, 8'hA3}, rx);
    repeat (8) @(negedge clock);
    `CHK(addr, 7'h55)
    `CHK(wdata, 8'hA3)
    `CHK(n_wr, 1)
  endtask
  task t_spi_rd;
    rdata = 8'h96;
    ccp_host_i.xfer({7'h2A, 1'b1, 8'h00}, rx);
    repeat (8) @(negedge clock);
    `CHK(rx[7:0], 8'h96)
    `CHK(addr, 7'h2A)
    `CHK(n_rd + n_wr, 2)
    psel = 1'b0;
    repeat (10) @(negedge clock);
    `CHK(mode, 1'b1)
  endtask
  initial begin
    t_i2c;
    t_spi_wr;
    t_spi_rd;
    end_sim;
  end
  initial begin
    #100us;
    n_errors++;
    end_sim;
  end
endmodule // codec_control_port_front_end_tb
`default_nettype wire
